// [dctu_pkg.sv]
/*
  Shared constants and types of the dual channel 8-bit timer unit: register
  offsets, reset values, mode encodings, channel configuration layout and the
  APB request and answer carriers.
  Assumes a single peripheral clock domain and a 12-bit APB byte address.
*/
package dctu_pkg;

  // Register byte offsets; channel registers repeat every stride.
  localparam logic [11:0] DCTU_CH_STRIDE = 12'h020;
  localparam logic [11:0] DCTU_CTRL_OFS = 12'h000;
  localparam logic [11:0] DCTU_CMPA_OFS = 12'h004;
  localparam logic [11:0] DCTU_CMPB_OFS = 12'h008;
  localparam logic [11:0] DCTU_CNT_OFS = 12'h00C;
  localparam logic [11:0] DCTU_START_OFS = 12'h100;
  localparam logic [11:0] DCTU_STOP_OFS = 12'h104;
  localparam logic [11:0] DCTU_STAT_OFS = 12'h108;
  localparam logic [11:0] DCTU_MASK_OFS = 12'h10C;

  // Reset values.
  localparam logic [7:0] DCTU_CMP_RST = 8'hFF;
  localparam logic [7:0] DCTU_CNT_RST = 8'h00;
  localparam logic [31:0] DCTU_RSV_READ = 32'h0000_0000;

  // Prescaler width and the divider ratios as powers of two.
  localparam int DCTU_PRE_W = 13;
  localparam int DCTU_NDIV = 7;
  localparam int DCTU_DIV_LOG2 [DCTU_NDIV] = '{0, 1, 3, 5, 6, 10, 13};
  localparam logic [2:0] DCTU_CLK_EXT = 3'h7;

  // Counter clear source.
  typedef enum logic [1:0] {
    DCTU_CLR_NONE = 2'h0,
    DCTU_CLR_A = 2'h1,
    DCTU_CLR_B = 2'h2,
    DCTU_CLR_EXT = 2'h3
  } dctu_clr_t;

  // Timer output waveform.
  typedef enum logic [1:0] {
    DCTU_OUT_OFF = 2'h0,
    DCTU_OUT_TOGGLE = 2'h1,
    DCTU_OUT_DUTY = 2'h2,
    DCTU_OUT_PWM = 2'h3
  } dctu_out_t;

  // Action taken on a linked event.
  typedef enum logic [1:0] {
    DCTU_ELC_NONE = 2'h0,
    DCTU_ELC_START = 2'h1,
    DCTU_ELC_EVCNT = 2'h2,
    DCTU_ELC_RESTART = 2'h3
  } dctu_elc_t;

  // Channel control register layout, bit 0 upward from clk_sel.
  typedef struct packed {
    logic dtc_en;
    dctu_elc_t elc_act;
    logic cmcount;
    logic cascade;
    dctu_out_t out_mode;
    dctu_clr_t clr_sel;
    logic [2:0] clk_sel;
  } dctu_chcfg_t;

  // Per channel event pulses.
  typedef struct packed {
    logic ovf;
    logic cmb;
    logic cma;
  } dctu_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dctu_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dctu_apb_rsp_t;

endpackage

// [dctu_channel.sv]
/*
  One 8-bit counter channel: count, compare A and B, clear and timer output.
  Assumes the parent supplies count, compare-check and clear strobes that are
  already synchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module dctu_channel (
  input wire logic core_clk,
  input wire logic reset,
  input wire dctu_pkg::dctu_chcfg_t cfg,
  input wire logic [7:0] cmpa,
  input wire logic [7:0] cmpb,
  input wire logic inc,
  input wire logic chk,
  input wire logic qual_a,
  input wire logic qual_b,
  input wire logic force_clr,
  input wire logic wr_cnt,
  input wire logic [7:0] wr_data,
  output logic [7:0] cnt,
  output var dctu_pkg::dctu_evt_t evt,
  output logic tout,
  output logic clr_now
);

  typedef struct packed {
    logic [7:0] cnt;
    dctu_pkg::dctu_evt_t evt;
    logic tout;
  } dctu_ch_st_t;

  dctu_ch_st_t s;
  dctu_ch_st_t next_s;
  logic hit_a;
  logic hit_b;

  // Compare is checked on the count edge, so a clear on match gives a period of cmp+1.
  // Kept out of the state process: a cascaded pair feeds this clear into the partner's
  // count enable, and a single process for both would read its own output.
  assign hit_a = chk && qual_a && (s.cnt == cmpa);
  assign hit_b = chk && qual_b && (s.cnt == cmpb);
  assign clr_now = force_clr || (hit_a && cfg.clr_sel == dctu_pkg::DCTU_CLR_A) ||
                   (hit_b && cfg.clr_sel == dctu_pkg::DCTU_CLR_B);

  // Next counter value, event pulses and output level.
  always_comb begin
    next_s = s;
    next_s.evt = '0;
    if (wr_cnt) begin
      next_s.cnt = wr_data;
    end else if (clr_now) begin
      next_s.cnt = dctu_pkg::DCTU_CNT_RST;
    end else if (inc) begin
      next_s.cnt = s.cnt + 8'h01;
      next_s.evt.ovf = (s.cnt == 8'hFF);
    end
    next_s.evt.cma = hit_a;
    next_s.evt.cmb = hit_b;
    // Output waveform from the compare matches; in duty mode B wins when both match at once.
    unique case (cfg.out_mode)
      dctu_pkg::DCTU_OUT_OFF: next_s.tout = 1'b0;
      dctu_pkg::DCTU_OUT_TOGGLE: next_s.tout = hit_a ? !s.tout : s.tout;
      dctu_pkg::DCTU_OUT_DUTY: begin
        if (hit_b) begin
          next_s.tout = 1'b0;
        end else if (hit_a) begin
          next_s.tout = 1'b1;
        end
      end
      dctu_pkg::DCTU_OUT_PWM: next_s.tout = (next_s.cnt < cmpa);
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.cnt <= dctu_pkg::DCTU_CNT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign cnt = s.cnt;
  assign evt = s.evt;
  assign tout = s.tout;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_ovf_wrap;
    evt.ovf |-> cnt == 8'h00 && $past(cnt) == 8'hFF;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");

  property p_cma_equal;
    evt.cma |-> $past(cnt) == $past(cmpa) && $past(chk);
  endproperty
  a_cma_equal: assert property (p_cma_equal) else $error("match A without equality");

  property p_clear_on_a;
    hit_a && cfg.clr_sel == dctu_pkg::DCTU_CLR_A && !wr_cnt |=> cnt == 8'h00 && evt.cma;
  endproperty
  a_clear_on_a: assert property (p_clear_on_a) else $error("no clear on match A");

endmodule

`default_nettype wire

// [dctu_timer_unit.sv]
/*
  Top of the 8-bit timer block: units of two channels, shared prescaler,
  cascade and compare-match count linking, event link, triggers, interrupt
  status and the APB register slave.
  Assumes external count clock and counter reset pins are asynchronous, event
  link inputs are one-cycle pulses on core_clk, and the APB master is APB3.
*/
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Count prescaled clock or external clock
// - Four units of two 8-bit channels
// - Compare A and B in 8/16-bit modes
// - Clear on match A, B or reset pin
// - Pulse or PWM output from matches
// - Cascade: even upper, odd lower byte
// - Odd channel counts even match A
// - Event outputs from first four channels
// - Linked event starts, counts or restarts
// - Match A/B requests start transfers
// - Even match A triggers A/D converter
// - Match activity makes serial basic clock
// - Start register starts channel counting
// - Per unit module stop halts counting
module dctu_timer_unit #(
  parameter int NUNITS = 4,
  parameter int ELC_CH = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire dctu_pkg::dctu_apb_req_t apb_req,
  output var dctu_pkg::dctu_apb_rsp_t apb_rsp,
  input wire logic [NUNITS-1:0] ext_clk_pin,
  input wire logic [NUNITS-1:0] ext_rst_pin,
  input wire logic [ELC_CH-1:0] elc_evt,
  output var dctu_pkg::dctu_evt_t [ELC_CH-1:0] elc_out,
  output logic [2*NUNITS-1:0] tout,
  output logic [NUNITS-1:0] adc_trig,
  output logic [2*NUNITS-1:0] data_transfer_controller_req_a,
  output logic [2*NUNITS-1:0] data_transfer_controller_req_b,
  output logic [NUNITS-1:0] serial_comm_interface_clk,
  output logic irq
);

  localparam int NCH = 2 * NUNITS;
  localparam int SW = 3 * NCH;

  typedef struct packed {
    dctu_pkg::dctu_apb_rsp_t rsp;
    dctu_pkg::dctu_chcfg_t [NCH-1:0] cfg;
    logic [NCH-1:0][7:0] cmpa;
    logic [NCH-1:0][7:0] cmpb;
    logic [NCH-1:0] run;
    logic [NUNITS-1:0] mstop;
    logic [SW-1:0] stat;
    logic [SW-1:0] mask;
    logic irq;
    logic [dctu_pkg::DCTU_PRE_W-1:0] pre;
    logic [NUNITS-1:0] eclk_s1;
    logic [NUNITS-1:0] eclk_s2;
    logic [NUNITS-1:0] eclk_s3;
    logic [NUNITS-1:0] erst_s1;
    logic [NUNITS-1:0] erst_s2;
    logic [NUNITS-1:0] erst_s3;
    logic [NUNITS-1:0] adc_trig;
    logic [NUNITS-1:0] sci_clk;
    logic [NCH-1:0] dtc_a;
    logic [NCH-1:0] dtc_b;
  } dctu_top_st_t;

  dctu_top_st_t s;
  dctu_top_st_t next_s;

  logic [7:0] div_tick;
  logic [NUNITS-1:0] eclk_rise;
  logic [NUNITS-1:0] erst_rise;
  logic [7:0] ch_cnt [NCH];
  dctu_pkg::dctu_evt_t ch_evt [NCH];
  logic ch_tout [NCH];
  logic clr_now [NCH];
  logic inc [NCH];
  logic chk [NCH];
  logic qual_a [NCH];
  logic qual_b [NCH];
  logic force_clr [NCH];
  logic own_tick [NCH];
  logic elc_inc [NCH];
  logic elc_rst [NCH];
  logic elc_start [NCH];
  logic wr_cnt [NCH];
  logic access;
  logic apb_wr;
  logic is_ch;
  logic is_glb;
  logic [2:0] ch_idx;

  // One shared prescaler; a ratio ticks when its low bits are all ones.
  for (genvar k = 0; k < 8; k++) begin : g_div
    if (k < dctu_pkg::DCTU_NDIV) begin : g_ratio
      localparam logic [12:0] DMASK = 13'((1 << dctu_pkg::DCTU_DIV_LOG2[k]) - 1);
      assign div_tick[k] = ((s.pre & DMASK) == DMASK);
    end else begin : g_none
      assign div_tick[k] = 1'b0;
    end
  end

  // Edge detect after the two-stage pin synchronisers.
  assign eclk_rise = s.eclk_s2 & ~s.eclk_s3;
  assign erst_rise = s.erst_s2 & ~s.erst_s3 & ~s.mstop; // A stopped unit ignores it.

  // Address decode; channel registers sit below the global block.
  assign access = apb_req.psel && apb_req.penable;
  assign apb_wr = access && s.rsp.pready && apb_req.pwrite;
  assign ch_idx = apb_req.paddr[7:5];
  assign is_ch = apb_req.paddr[11:8] == 4'h0 && !apb_req.paddr[4] &&
                 apb_req.paddr[1:0] == 2'h0 && {1'b0, ch_idx} < 4'(NCH);
  assign is_glb = apb_req.paddr[11:4] == dctu_pkg::DCTU_START_OFS[11:4] &&
                  apb_req.paddr[1:0] == 2'h0;

  // Channels of each unit, paired even and odd.
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int U = i / 2;
    localparam logic [2:0] CI = 3'(i);
    assign own_tick[i] = s.run[i] && !s.mstop[U] &&
                         (s.cfg[i].clk_sel == dctu_pkg::DCTU_CLK_EXT ? eclk_rise[U] :
                          div_tick[s.cfg[i].clk_sel]);
    if (i < ELC_CH) begin : g_elc
      assign elc_inc[i] = elc_evt[i] && !s.mstop[U] &&
                          s.cfg[i].elc_act == dctu_pkg::DCTU_ELC_EVCNT;
      assign elc_rst[i] = elc_evt[i] && !s.mstop[U] &&
                          s.cfg[i].elc_act == dctu_pkg::DCTU_ELC_RESTART;
      assign elc_start[i] = elc_evt[i] &&
                            s.cfg[i].elc_act == dctu_pkg::DCTU_ELC_START;
      assign elc_out[i] = ch_evt[i];
    end else begin : g_noelc
      assign elc_inc[i] = 1'b0;
      assign elc_rst[i] = 1'b0;
      assign elc_start[i] = 1'b0;
    end
    if (i % 2 == 1) begin : g_odd
      // Lower byte in cascade; counts even match A in compare-match count mode.
      assign inc[i] = s.cfg[i].cmcount ? (!s.mstop[U] && ch_evt[i-1].cma) :
                      (own_tick[i] || elc_inc[i]);
      assign chk[i] = inc[i];
      assign qual_a[i] = 1'b1;
      assign qual_b[i] = 1'b1;
      assign force_clr[i] = elc_rst[i] || (s.cfg[i].clr_sel == dctu_pkg::DCTU_CLR_EXT &&
                            erst_rise[U]) || (s.cfg[i-1].cascade && clr_now[i-1]);
    end else begin : g_even
      // Upper byte in cascade: carries on the lower byte's wrap, matches on 16 bits.
      assign inc[i] = s.cfg[i].cascade ? (inc[i+1] && ch_cnt[i+1] == 8'hFF &&
                      !clr_now[i+1] && !wr_cnt[i+1]) : (own_tick[i] || elc_inc[i]);
      assign chk[i] = s.cfg[i].cascade ? inc[i+1] : inc[i];
      assign qual_a[i] = !s.cfg[i].cascade || ch_cnt[i+1] == s.cmpa[i+1];
      assign qual_b[i] = !s.cfg[i].cascade || ch_cnt[i+1] == s.cmpb[i+1];
      assign force_clr[i] = elc_rst[i] || (s.cfg[i].clr_sel == dctu_pkg::DCTU_CLR_EXT &&
                            erst_rise[U]);
    end
    assign wr_cnt[i] = apb_wr && is_ch && ch_idx == CI &&
                       apb_req.paddr[3:0] == dctu_pkg::DCTU_CNT_OFS[3:0];
    assign tout[i] = ch_tout[i];

    dctu_channel u_ch (
      .core_clk(core_clk),
      .reset(reset),
      .cfg(s.cfg[i]),
      .cmpa(s.cmpa[i]),
      .cmpb(s.cmpb[i]),
      .inc(inc[i]),
      .chk(chk[i]),
      .qual_a(qual_a[i]),
      .qual_b(qual_b[i]),
      .force_clr(force_clr[i]),
      .wr_cnt(wr_cnt[i]),
      .wr_data(apb_req.pwdata[7:0]),
      .cnt(ch_cnt[i]),
      .evt(ch_evt[i]),
      .tout(ch_tout[i]),
      .clr_now(clr_now[i])
    );
  end

  // Next state: bus slave, register writes, status, triggers and synchronisers.
  always_comb begin
    logic [31:0] rdata;
    logic ok;
    logic [SW-1:0] ev;
    logic [SW-1:0] w1c;
    rdata = dctu_pkg::DCTU_RSV_READ;
    ok = 1'b0;
    ev = '0;
    w1c = '0;
    next_s = s;
    next_s.pre = s.pre + 13'h0001;
    next_s.eclk_s1 = ext_clk_pin;
    next_s.eclk_s2 = s.eclk_s1;
    next_s.eclk_s3 = s.eclk_s2;
    next_s.erst_s1 = ext_rst_pin;
    next_s.erst_s2 = s.erst_s1;
    next_s.erst_s3 = s.erst_s2;
    if (is_ch) begin
      ok = 1'b1;
      case (apb_req.paddr[3:0])
        dctu_pkg::DCTU_CTRL_OFS[3:0]: rdata = 32'(s.cfg[ch_idx]);
        dctu_pkg::DCTU_CMPA_OFS[3:0]: rdata = {24'h000000, s.cmpa[ch_idx]};
        dctu_pkg::DCTU_CMPB_OFS[3:0]: rdata = {24'h000000, s.cmpb[ch_idx]};
        default: rdata = {24'h000000, ch_cnt[ch_idx]};
      endcase
    end else if (is_glb) begin
      ok = 1'b1;
      case (apb_req.paddr[3:0])
        dctu_pkg::DCTU_START_OFS[3:0]: rdata = 32'(s.run);
        dctu_pkg::DCTU_STOP_OFS[3:0]: rdata = 32'(s.mstop);
        dctu_pkg::DCTU_STAT_OFS[3:0]: rdata = 32'(s.stat);
        default: rdata = 32'(s.mask);
      endcase
    end
    // Answer one cycle into the access phase; unmapped addresses get an error.
    next_s.rsp.pready = access && !s.rsp.pready;
    next_s.rsp.pslverr = access && !s.rsp.pready && !ok;
    next_s.rsp.prdata = (access && !s.rsp.pready && ok) ? rdata : 32'h0000_0000;
    if (apb_wr && is_ch) begin
      case (apb_req.paddr[3:0])
        dctu_pkg::DCTU_CTRL_OFS[3:0]: next_s.cfg[ch_idx] = apb_req.pwdata[11:0];
        dctu_pkg::DCTU_CMPA_OFS[3:0]: next_s.cmpa[ch_idx] = apb_req.pwdata[7:0];
        dctu_pkg::DCTU_CMPB_OFS[3:0]: next_s.cmpb[ch_idx] = apb_req.pwdata[7:0];
        default: ;
      endcase
    end else if (apb_wr && is_glb) begin
      case (apb_req.paddr[3:0])
        dctu_pkg::DCTU_START_OFS[3:0]: next_s.run = apb_req.pwdata[NCH-1:0];
        dctu_pkg::DCTU_STOP_OFS[3:0]: next_s.mstop = apb_req.pwdata[NUNITS-1:0];
        dctu_pkg::DCTU_STAT_OFS[3:0]: w1c = apb_req.pwdata[SW-1:0];
        default: next_s.mask = apb_req.pwdata[SW-1:0];
      endcase
    end
    for (int i = 0; i < NCH; i++) begin
      // A linked start or restart beats a software write to the start register.
      if (elc_start[i] || elc_rst[i]) begin
        next_s.run[i] = 1'b1;
      end
      ev[3*i +: 3] = ch_evt[i];
      next_s.dtc_a[i] = ch_evt[i].cma && s.cfg[i].dtc_en;
      next_s.dtc_b[i] = ch_evt[i].cmb && s.cfg[i].dtc_en;
    end
    for (int u = 0; u < NUNITS; u++) begin
      next_s.adc_trig[u] = ch_evt[2*u].cma;
      next_s.sci_clk[u] = s.sci_clk[u] ^ ch_evt[2*u+1].cma;
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    next_s.stat = (s.stat & ~w1c) | ev;
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  // State register.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.cmpa <= {NCH{dctu_pkg::DCTU_CMP_RST}};
      s.cmpb <= {NCH{dctu_pkg::DCTU_CMP_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp = s.rsp;
  assign adc_trig = s.adc_trig;
  assign data_transfer_controller_req_a = s.dtc_a;
  assign data_transfer_controller_req_b = s.dtc_b;
  assign serial_comm_interface_clk = s.sci_clk;
  assign irq = s.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_irq_cma;
    ch_evt[0].cma && s.mask[0] |=> s.stat[0] && irq;
  endproperty
  a_irq_cma: assert property (p_irq_cma) else $error("match A did not raise irq");

  property p_adc_trig;
    ch_evt[0].cma |=> adc_trig[0];
  endproperty
  a_adc_trig: assert property (p_adc_trig) else $error("missing A/D trigger");

  property p_sci_toggle;
    ch_evt[1].cma |=> serial_comm_interface_clk[0] != $past(serial_comm_interface_clk[0]);
  endproperty
  a_sci_toggle: assert property (p_sci_toggle) else $error("serial clock did not toggle");

  property p_start_reg;
    apb_wr && is_glb && apb_req.paddr[3:0] == dctu_pkg::DCTU_START_OFS[3:0] &&
      apb_req.pwdata[0] |=> s.run[0];
  endproperty
  a_start_reg: assert property (p_start_reg) else $error("start write ignored");

  property p_mstop_hold;
    s.mstop[0] && !wr_cnt[0] && !elc_rst[0] && !s.cfg[0].cascade |=> ch_cnt[0] == $past(ch_cnt[0]);
  endproperty
  a_mstop_hold: assert property (p_mstop_hold) else $error("stopped unit counted");

  property p_cmcount;
    s.cfg[1].cmcount && !s.mstop[0] && ch_evt[0].cma && !wr_cnt[1] && !clr_now[1]
      |=> ch_cnt[1] == $past(ch_cnt[1]) + 8'h01;
  endproperty
  a_cmcount: assert property (p_cmcount) else $error("odd channel missed match count");

  property p_cascade_carry;
    s.cfg[0].cascade && inc[0] && !clr_now[0] && !wr_cnt[0]
      |=> ch_cnt[0] == $past(ch_cnt[0]) + 8'h01 && ch_cnt[1] == 8'h00;
  endproperty
  a_cascade_carry: assert property (p_cascade_carry) else $error("bad 16-bit carry");

  property p_div8_hold;
    s.cfg[0].clk_sel == 3'h2 && !s.cfg[0].cascade && s.pre[2:0] != 3'h7 && !wr_cnt[0] &&
      !force_clr[0] && !elc_inc[0] |=> ch_cnt[0] == $past(ch_cnt[0]);
  endproperty
  a_div8_hold: assert property (p_div8_hold) else $error("counted off the divide-by-8 tick");

  property p_elc_start;
    elc_start[2] |=> s.run[2];
  endproperty
  a_elc_start: assert property (p_elc_start) else $error("linked start ignored");

  property p_dtc_req;
    ch_evt[0].cmb && s.cfg[0].dtc_en |=> data_transfer_controller_req_b[0];
  endproperty
  a_dtc_req: assert property (p_dtc_req) else $error("missing transfer request");

endmodule

`default_nettype wire

// [dctu_pin_partner.sv]
/*
  Far side pin driver for the timer block: external count clock and
  external counter reset pins of each unit.
  Assumes the testbench calls its task from one process at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module dctu_pin_partner (
  input wire logic core_clk,
  output logic [3:0] ext_clk_pin,
  output logic [3:0] ext_rst_pin
);
  // Both pin groups idle low until a pulse is asked for.
  initial begin
    ext_clk_pin = 4'h0;
    ext_rst_pin = 4'h0;
  end

  // One rising edge on a unit pin, held three edges so the synchroniser sees it.
  task automatic pulse(input bit rst, input int u);
    @(posedge core_clk);
    if (rst) ext_rst_pin[u] <= 1'b1;
    else ext_clk_pin[u] <= 1'b1;
    repeat (3) @(posedge core_clk);
    ext_rst_pin[u] <= 1'b0;
    ext_clk_pin[u] <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// [tb_dual_channel_8bit_timer_unit.sv]
/*
  Self-checking bench of the timer block: APB register tasks, one task per
  scenario and a pin partner for the external count and reset pins.
  Assumes the register map and one wait state APB timing of the design.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_dual_channel_8bit_timer_unit;
  localparam logic [11:0] ST = dctu_pkg::DCTU_START_OFS;
  localparam logic [11:0] SP = dctu_pkg::DCTU_STOP_OFS;
  localparam logic [11:0] SS = dctu_pkg::DCTU_STAT_OFS;
  localparam logic [11:0] SM = dctu_pkg::DCTU_MASK_OFS;
  localparam logic [11:0] CA = dctu_pkg::DCTU_CMPA_OFS;
  localparam logic [11:0] CB = dctu_pkg::DCTU_CMPB_OFS;
  localparam logic [11:0] CN = dctu_pkg::DCTU_CNT_OFS;
  localparam logic [11:0] CT = dctu_pkg::DCTU_CTRL_OFS;
  logic core_clk;
  logic reset;
  dctu_pkg::dctu_apb_req_t req;
  dctu_pkg::dctu_apb_rsp_t rsp;
  logic [3:0] ext_clk_pin, ext_rst_pin, elc_evt, adc_trig, sci_clk;
  dctu_pkg::dctu_evt_t [3:0] elc_out;
  logic [7:0] tout, dreq_a, dreq_b, w;
  logic irq, er;
  logic [31:0] rd, tmp;
  int miscompares, num_checks;

  // Pulses that the period task can watch, picked by index.
  assign w = {elc_out[2].cma, dreq_b[0], elc_out[1].ovf, dreq_a[0], adc_trig[0],
              elc_out[0].ovf, elc_out[0].cmb, elc_out[0].cma};

  dctu_timer_unit dut_u (.core_clk(core_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .ext_clk_pin(ext_clk_pin), .ext_rst_pin(ext_rst_pin), .elc_evt(elc_evt),
    .elc_out(elc_out), .tout(tout), .adc_trig(adc_trig),
    .data_transfer_controller_req_a(dreq_a), .data_transfer_controller_req_b(dreq_b),
    .serial_comm_interface_clk(sci_clk), .irq(irq));

  dctu_pin_partner pin_u (.core_clk(core_clk), .ext_clk_pin(ext_clk_pin),
    .ext_rst_pin(ext_rst_pin));

  // Free running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wen, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wen, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read");
  endtask

  function automatic logic [11:0] ra(input int n, input logic [11:0] ofs);
    return dctu_pkg::DCTU_CH_STRIDE * 12'(n) + ofs;
  endfunction

  // Control word: hi holds dtc enable, link action, match count and cascade.
  function automatic logic [31:0] cw(input logic [2:0] k, input logic [1:0] clr,
                                     input logic [1:0] o, input logic [4:0] hi);
    return {20'h0, hi, o, clr, k};
  endfunction

  // A short reset between scenarios keeps each one independent of the last.
  task automatic rst();
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Edges between two consecutive pulses of watched signal i.
  task automatic per(input int i, input int exp);
    int n;
    for (int r = 0; r < 2; r++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (w[i] !== 1'b1 && n < 20000);
    end
    chk(n, exp, "period");
  endtask

  task automatic ev(input logic [3:0] b);
    @(posedge core_clk);
    elc_evt <= b;
    @(posedge core_clk);
    elc_evt <= 4'h0;
  endtask

  task automatic t_regs();
    rdc(ra(0, CA), 32'(dctu_pkg::DCTU_CMP_RST));
    rdc(ra(7, CN), 32'h0);
    wr(ra(5, CB), 32'h5A);
    rdc(ra(5, CB), 32'h5A);
    rdc(SS, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, dctu_pkg::DCTU_RSV_READ, "unmapped data");
  endtask

  // Match A at zero with clear on A pulses once per prescaler tick.
  task automatic t_div();
    for (int k = 0; k < dctu_pkg::DCTU_NDIV; k++) begin
      rst();
      wr(ra(0, CA), 32'h0);
      wr(ra(0, CT), cw(3'(k), 2'h1, 2'h0, 5'h0));
      wr(ST, 32'h1);
      per(0, 1 << dctu_pkg::DCTU_DIV_LOG2[k]);
    end
  endtask

  task automatic t_clr();
    rst();
    wr(SM, 32'h1);
    wr(ra(0, CA), 32'h3);
    wr(ra(0, CB), 32'h5);
    wr(ra(0, CT), cw(3'h0, 2'h1, 2'h0, 5'h10));
    wr(ST, 32'h1);
    per(0, 4);
    per(4, 4);
    per(3, 4);
    wr(ra(0, CT), cw(3'h0, 2'h2, 2'h0, 5'h10));
    per(1, 6);
    per(6, 6);
    chk({31'h0, irq}, 32'h1, "match irq");
  endtask

  task automatic t_ovf();
    rst();
    wr(ra(0, CT), cw(3'h0, 2'h0, 2'h0, 5'h0));
    wr(ST, 32'h1);
    per(2, 256);
    wr(ST, 32'h0);
    rdc(SS, 32'h7);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(SM, 32'h4);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(SS, 32'h7);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask

  // Period of four counts; every output mode is measured over a whole number of periods.
  task automatic t_pwm();
    int h;
    rst();
    wr(ra(0, CA), 32'h2);
    wr(ra(0, CB), 32'h3);
    wr(ra(0, CT), cw(3'h0, 2'h2, 2'h0, 5'h0));
    wr(ST, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(ra(0, CT), cw(3'h0, 2'h2, 2'(m), 5'h0));
      repeat (8) @(posedge core_clk);
      h = 0;
      repeat (40) begin
        @(posedge core_clk);
        if (tout[0] === 1'b1) h++;
      end
      chk(h, (m == 0) ? 0 : ((m == 2) ? 10 : 20), "output high time");
    end
  endtask

  task automatic t_ext();
    rst();
    wr(ra(2, CT), cw(3'h7, 2'h0, 2'h0, 5'h0));
    wr(ST, 32'h4);
    repeat (5) pin_u.pulse(1'b0, 1);
    rdc(ra(2, CN), 32'h5);
    wr(ra(2, CT), cw(3'h7, 2'h3, 2'h0, 5'h0));
    pin_u.pulse(1'b1, 1);
    rdc(ra(2, CN), 32'h0);
  endtask

  task automatic t_link();
    rst();
    wr(ra(0, CA), 32'h1);
    wr(ra(0, CT), cw(3'h0, 2'h1, 2'h0, 5'h0));
    wr(ra(1, CT), cw(3'h0, 2'h0, 2'h0, 5'h02));
    wr(ST, 32'h1);
    per(5, 512);
    tmp[0] = sci_clk[0];
    repeat (512) @(posedge core_clk);
    chk({31'h0, sci_clk[0]}, {31'h0, ~tmp[0]}, "serial clock");
    rst();
    wr(ra(1, CA), 32'h0);
    wr(ra(1, CT), cw(3'h0, 2'h0, 2'h0, 5'h0));
    wr(ra(0, CA), 32'h1);
    wr(ra(0, CT), cw(3'h0, 2'h1, 2'h0, 5'h01));
    wr(ST, 32'h3);
    per(0, 257);
  endtask

  task automatic t_elc();
    rst();
    wr(ra(2, CA), 32'h0);
    wr(ra(2, CT), cw(3'h0, 2'h1, 2'h0, 5'h04));
    ev(4'h4);
    rdc(ST, 32'h4);
    per(7, 1);
    wr(ra(3, CT), cw(3'h7, 2'h0, 2'h0, 5'h08));
    wr(ST, 32'hC);
    repeat (3) ev(4'h8);
    rdc(ra(3, CN), 32'h3);
    wr(ra(3, CT), cw(3'h7, 2'h0, 2'h0, 5'h0C));
    ev(4'h8);
    rdc(ra(3, CN), 32'h0);
  endtask

  task automatic t_stop();
    rst();
    wr(ra(0, CT), cw(3'h0, 2'h0, 2'h0, 5'h0));
    wr(ST, 32'h1);
    wr(SP, 32'h1);
    apb(1'b0, ra(0, CN), 32'h0);
    tmp = rd;
    repeat (20) @(posedge core_clk);
    rdc(ra(0, CN), tmp);
  endtask

  // Main sequence: long reset, then every scenario in turn.
  initial begin
    reset = 1'b1;
    req = '0;
    elc_evt = 4'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_div();
    t_clr();
    t_ovf();
    t_pwm();
    t_ext();
    t_link();
    t_elc();
    t_stop();
    end_of_test();
  end

  // Watchdog at 70000 cycles, well beyond the roughly 22000 cycles the scenarios need.
  initial begin
    #700000;
    miscompares++;
    end_of_test();
  end
endmodule

`default_nettype wire
